// *** hw/dlde_decode.sv ***
// Per-command classification: source use and destination space
`timescale 1ns/10ps
module dlde_decode
  import dlde_pkg::*;
(
  input  wire logic [3:0] opcode,
  output logic            is_draw,
  output logic            to_work,
  output logic            use_src,
  output logic            src_binary,
  output logic            legal
);
  // Each drawing command fixes its own source and destination
  always_comb begin
    is_draw    = 1'b0;
    to_work    = 1'b0;
    use_src    = 1'b0;
    src_binary = 1'b0;
    legal      = 1'b1;
    case (dlde_op_e'(opcode))
      DLDE_OP_POLY: begin
        is_draw = 1'b1;
        use_src = 1'b1; // [RULE8]
      end
      DLDE_OP_LINE:  is_draw = 1'b1;
      DLDE_OP_WPOLY: begin
        is_draw    = 1'b1;
        to_work    = 1'b1; // [RULE8]
        use_src    = 1'b1;
        src_binary = 1'b1;
      end
      DLDE_OP_WLINE: begin
        is_draw = 1'b1;
        to_work = 1'b1;
      end
      DLDE_OP_CPSET, DLDE_OP_OFFSET, DLDE_OP_SCLIPW, DLDE_OP_UCLIPW,
      DLDE_OP_JUMP, DLDE_OP_CALL, DLDE_OP_RET, DLDE_OP_IDLE,
      DLDE_OP_VSYNC, DLDE_OP_INTR, DLDE_OP_END: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end
endmodule : dlde_decode

// *** hw/dlde_engine.sv ***
// Display list fetch and drawing command sequencer
// How it works
// [RULE1] Screen origin top-left, X right, Y down
// [RULE2] Pixel element width selectable 16 or 8
// [RULE3] Render coordinate is screen plus command offset
// [RULE4] Clipping compares screen coordinates, not rendering
// [RULE5] Multi-valued source read from command's rectangle
// [RULE6] Binary source: address, width, height, 1bpp
// [RULE7] Work coordinate maps one-to-one, one bit
// [RULE8] Source use and destination decided per command
// [RULE9] Jump replaces display list fetch address
// [RULE10] Only one subroutine level supported
// [RULE11] Interrupt command halts and raises request
// [RULE12] Separate system and user clip windows
// [RULE13] Idle command simply fetches the next
// [RULE14] Suspend drawing until vertical sync, then resume
// [RULE15] Seven interrupt event sources provided
// [RULE16] Pointer, offset and clip setting commands accepted
// [RULE17] Return resumes after the call command
`timescale 1ns/10ps
module dlde_engine
  import dlde_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              start,        // Begin list at start_addr
  input  wire logic [ADDR_W-1:0] start_addr,
  input  wire logic              resume,       // Host releases an interrupt halt
  input  wire logic              vsync_pin,    // Vertical sync, asynchronous
  input  wire logic              frame_pin,    // Frame marker, asynchronous
  input  wire logic              dma_done,     // DMA transfer end pulse
  output logic                   mem_req,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic              mem_ack,
  input  wire logic [WORD_W-1:0] mem_rdata,
  output logic                   draw_valid,
  output dlde_draw_s             draw,
  input  wire logic              draw_ready,
  output dlde_irq_s              irq,
  output logic                   busy
);
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_ARG, S_EXEC, S_DRAW, S_WAITV, S_HALT}
    dlde_state_e;

  // Two-stage synchronisers for the pins
  logic [1:0] vs_sync;
  logic [1:0] fr_sync;
  logic       vs_prev;
  logic       fr_prev;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vs_sync <= 2'h0;
      fr_sync <= 2'h0;
      vs_prev <= 1'b0;
      fr_prev <= 1'b0;
    end else begin
      vs_sync <= {vs_sync[0], vsync_pin};
      fr_sync <= {fr_sync[0], frame_pin};
      vs_prev <= vs_sync[1];
      fr_prev <= fr_sync[1];
    end
  end
  logic vs_rise;
  logic fr_rise;
  assign vs_rise = vs_sync[1] & ~vs_prev;
  assign fr_rise = fr_sync[1] & ~fr_prev;

  dlde_state_e       state, next_state;
  logic [ADDR_W-1:0] pc, next_pc;
  logic [ADDR_W-1:0] ret_pc, next_ret_pc;
  logic              in_sub, next_in_sub;
  logic [WORD_W-1:0] cmd, next_cmd;
  logic [WORD_W-1:0] arg, next_arg;
  dlde_xy_s          ofs, next_ofs;
  dlde_xy_s          cur, next_cur;
  dlde_win_s         system_clip_cmd, next_system_clip_cmd;
  dlde_win_s         user_clip_cmd, next_user_clip_cmd;
  logic              depth16, next_depth16;
  dlde_draw_s        next_draw;
  logic              next_draw_valid;
  dlde_irq_s         next_irq;

  logic       is_draw, to_work, use_src, src_binary, legal;
  logic [3:0] opc;
  assign opc = cmd[OPC_LSB +: OPC_W];

  dlde_decode u_decode (
    .opcode     (opc),
    .is_draw    (is_draw),
    .to_work    (to_work),
    .use_src    (use_src),
    .src_binary (src_binary),
    .legal      (legal)
  );

  // Clip test in screen space, against both windows
  function automatic logic outside(input dlde_xy_s p, input dlde_win_s w);
    outside = (p.x < w.lo.x) || (p.x > w.hi.x) || (p.y < w.lo.y) || (p.y > w.hi.y);
  endfunction

  dlde_xy_s scr_pt;
  assign scr_pt = arg;  // Argument carries an absolute screen point [RULE1]

  // Sequencer next-state logic
  always_comb begin
    next_state      = state;
    next_pc         = pc;
    next_ret_pc     = ret_pc;
    next_in_sub     = in_sub;
    next_cmd        = cmd;
    next_arg        = arg;
    next_ofs        = ofs;
    next_cur        = cur;
    next_system_clip_cmd      = system_clip_cmd;
    next_user_clip_cmd      = user_clip_cmd;
    next_depth16    = depth16;
    next_draw       = draw;
    next_draw_valid = draw_valid & ~draw_ready;
    next_irq        = '0;
    next_irq.sync_det  = vs_rise;                // [RULE15]
    next_irq.vblank    = vs_sync[1];
    next_irq.frame_det = fr_rise;
    next_irq.dma_end   = dma_done;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_pc    = start_addr;
          next_in_sub = 1'b0;
          next_state = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          next_cmd   = mem_rdata;
          next_pc    = pc + ADDR_W'(1);
          next_state = S_ARG;
        end
      end
      S_ARG: begin
        // Every command carries one argument word
        if (mem_ack) begin
          next_arg   = mem_rdata;
          next_pc    = pc + ADDR_W'(1);
          next_state = S_EXEC;
        end
      end
      S_EXEC: begin
        next_state = S_FETCH;
        if (!legal) begin
          next_irq.cmd_err   = 1'b1;
          next_irq.cmd_abort = 1'b1;
          next_state         = S_IDLE;
        end else if (is_draw) begin
          next_draw.op         = dlde_op_e'(opc);
          next_draw.to_work    = to_work;       // [RULE7]
          next_draw.use_src    = use_src;       // [RULE5]
          next_draw.src_binary = src_binary;    // [RULE6]
          next_draw.depth16    = depth16;       // [RULE2]
          next_draw.clip_en    = cmd[CLIP_BIT];
          next_draw.screen_xy  = scr_pt;
          next_draw.render_xy.x = 16'(scr_pt.x + ofs.x); // [RULE3]
          next_draw.render_xy.y = 16'(scr_pt.y + ofs.y);
          next_draw.clipped    = cmd[CLIP_BIT] &
            (outside(scr_pt, system_clip_cmd) | outside(scr_pt, user_clip_cmd)); // [RULE4]
          next_draw.src_addr   = cmd[ADDR_W-1:0];
          next_cur             = scr_pt;
          next_draw_valid      = 1'b1;
          next_state           = S_DRAW;
        end else begin
          case (dlde_op_e'(opc))
            DLDE_OP_CPSET:  next_cur = arg;                     // [RULE16]
            DLDE_OP_OFFSET: begin
              next_ofs     = arg;                               // [RULE16]
              next_depth16 = cmd[DEPTH_BIT];                    // [RULE2]
            end
            DLDE_OP_SCLIPW: next_system_clip_cmd = {cmd[15:0], 16'h0000, arg}; // [RULE12]
            DLDE_OP_UCLIPW: next_user_clip_cmd = {cmd[15:0], 16'h0000, arg}; // [RULE12]
            DLDE_OP_JUMP:   next_pc = arg[ADDR_W-1:0];          // [RULE9]
            DLDE_OP_CALL: begin
              if (in_sub) begin
                next_irq.cmd_err   = 1'b1;                      // [RULE10]
                next_irq.cmd_abort = 1'b1;
                next_state         = S_IDLE;
              end else begin
                next_ret_pc = pc;                               // [RULE17]
                next_in_sub = 1'b1;
                next_pc     = arg[ADDR_W-1:0];
              end
            end
            DLDE_OP_RET: begin
              next_pc     = ret_pc;                             // [RULE17]
              next_in_sub = 1'b0;
            end
            DLDE_OP_IDLE:  next_state = S_FETCH;                // [RULE13]
            DLDE_OP_VSYNC: next_state = S_WAITV;                // [RULE14]
            DLDE_OP_INTR: begin
              // Halt reports through the command end source, no spare bit
              next_irq.cmd_end = 1'b1;                          // [RULE11]
              next_state       = S_HALT;
            end
            DLDE_OP_END: begin
              next_irq.cmd_end = 1'b1;
              next_state       = S_IDLE;
            end
            default: next_state = S_FETCH;
          endcase
        end
      end
      S_DRAW: if (draw_ready) next_state = S_FETCH;
      S_WAITV: if (vs_rise) next_state = S_FETCH;               // [RULE14]
      S_HALT: if (resume) next_state = S_FETCH;                 // [RULE11]
      default: next_state = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= S_IDLE;
      pc         <= FETCH_RST;
      ret_pc     <= FETCH_RST;
      in_sub     <= 1'b0;
      cmd        <= '0;
      arg        <= '0;
      ofs        <= '0;
      cur        <= '0;
      system_clip_cmd      <= '0;
      user_clip_cmd      <= '0;
      depth16    <= 1'b1;
      draw       <= '0;
      draw_valid <= 1'b0;
      irq        <= '0;
    end else begin
      state      <= next_state;
      pc         <= next_pc;
      ret_pc     <= next_ret_pc;
      in_sub     <= next_in_sub;
      cmd        <= next_cmd;
      arg        <= next_arg;
      ofs        <= next_ofs;
      cur        <= next_cur;
      system_clip_cmd      <= next_system_clip_cmd;
      user_clip_cmd      <= next_user_clip_cmd;
      depth16    <= next_depth16;
      draw       <= next_draw;
      draw_valid <= next_draw_valid;
      irq        <= next_irq;
    end
  end

  // Fetch requests are combinational; the pc is the address
  assign mem_req  = (state == S_FETCH) || (state == S_ARG);
  assign mem_addr = pc;
  assign busy     = (state != S_IDLE);

  chk_jump_target: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE9]
    (state == S_EXEC && opc == DLDE_OP_JUMP && legal) |=> pc == $past(arg[ADDR_W-1:0]))
    else $error("jump did not load fetch address");
  chk_return_point: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE17]
    (state == S_EXEC && opc == DLDE_OP_CALL && !in_sub) |=> ret_pc == $past(pc) && in_sub)
    else $error("call did not save return point");
  chk_call_depth: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE10]
    (state == S_EXEC && opc == DLDE_OP_CALL && in_sub) |=> state == S_IDLE && irq.cmd_err)
    else $error("nested call not refused");
  chk_intr_halt: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE11]
    (state == S_EXEC && opc == DLDE_OP_INTR) |=> state == S_HALT && !mem_req && irq.cmd_end)
    else $error("interrupt command did not halt");
  chk_vsync_wait: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE14]
    (state == S_WAITV && !vs_rise) |=> state == S_WAITV)
    else $error("drawing resumed before vertical sync");
  chk_idle_next: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
    (state == S_EXEC && opc == DLDE_OP_IDLE) |=> state == S_FETCH && !draw_valid [*1])
    else $error("idle command did work");
  chk_render_ofs: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
    (state == S_EXEC && is_draw) |=> draw.render_xy.x == draw.screen_xy.x + ofs.x)
    else $error("render offset wrong");
  chk_clip_screen: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE4]
    (state == S_EXEC && is_draw && !cmd[CLIP_BIT]) |=> !draw.clipped)
    else $error("clip applied without request");
  chk_dest_space: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE8]
    (state == S_EXEC && opc == DLDE_OP_WLINE) |=> draw.to_work && !draw.use_src)
    else $error("work line destination wrong");
endmodule : dlde_engine

// *** hw/dlde_pkg.sv ***
// Package for the display list drawing engine: opcodes, layouts, constants
package dlde_pkg;
  localparam int ADDR_W      = 24;
  localparam int WORD_W      = 32;
  localparam int COORD_W     = 16;
  // Opcode field position in a command word
  localparam int OPC_LSB     = 28;
  localparam int OPC_W       = 4;
  // Option bit positions in a command word
  localparam int CLIP_BIT    = 27;
  localparam int DEPTH_BIT   = 26;
  // Reset values
  localparam logic [23:0] FETCH_RST = 24'h000000;
  localparam logic [15:0] COORD_RST = 16'h0000;
  // Clock rate and handshake timing
  localparam int CLK_MHZ     = 200;
  localparam int ERR_NS      = 20;
  localparam int ERR_CYC     = (ERR_NS * CLK_MHZ + 999) / 1000;

  // Command opcodes
  typedef enum logic [3:0] {
    DLDE_OP_POLY   = 4'h0,  // Four-vertex surface, rendering dest, source read
    DLDE_OP_LINE   = 4'h1,  // Line, rendering dest, no source
    DLDE_OP_WPOLY  = 4'h2,  // Work surface, work dest, binary source
    DLDE_OP_WLINE  = 4'h3,  // Work line, work dest, no source
    DLDE_OP_CPSET  = 4'h4,  // Current pointer setting
    DLDE_OP_OFFSET = 4'h5,  // Local offset setting
    DLDE_OP_SCLIPW = 4'h6,  // system_clip_cmd
    DLDE_OP_UCLIPW = 4'h7,  // user_clip_cmd
    DLDE_OP_JUMP   = 4'h8,
    DLDE_OP_CALL   = 4'h9,  // subroutine_call_cmd
    DLDE_OP_RET    = 4'ha,
    DLDE_OP_IDLE   = 4'hb,  // idle_fetch_cmd
    DLDE_OP_VSYNC  = 4'hc,  // Suspend until vertical sync
    DLDE_OP_INTR   = 4'hd,  // Interrupt and halt
    DLDE_OP_END    = 4'he
  } dlde_op_e;

  // Coordinate pair
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } dlde_xy_s;

  // Clip window in screen coordinates
  typedef struct packed {
    dlde_xy_s lo;
    dlde_xy_s hi;
  } dlde_win_s;

  // Request to the pixel pipeline
  typedef struct packed {
    dlde_op_e       op;
    logic           to_work;    // Work space destination
    logic           use_src;    // Source data referenced
    logic           src_binary; // One bit per pixel source
    logic           depth16;    // 16 bits per pixel element
    logic           clip_en;
    dlde_xy_s       render_xy;  // Rendering coordinate
    dlde_xy_s       screen_xy;  // Screen coordinate for clip test
    logic           clipped;    // Point outside the clip windows
    logic [23:0]    src_addr;   // Source top-left physical address
  } dlde_draw_s;

  // Interrupt events: one-cycle pulses, except vblank which follows vertical sync
  typedef struct packed {
    logic sync_det;
    logic frame_det;
    logic dma_end;
    logic cmd_err;
    logic vblank;
    logic cmd_end;
    logic cmd_abort;
  } dlde_irq_s;
endpackage : dlde_pkg

// *** verification/dlde_far_model.sv ***
// Graphics memory and pixel pipeline model facing the drawing engine
`timescale 1ns/10ps
module dlde_far_model
  import dlde_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              slow,
  input  wire logic              mem_req,
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic                   mem_ack,
  output logic [WORD_W-1:0]      mem_rdata,
  input  wire logic              draw_valid,
  input  wire dlde_draw_s        draw,
  output logic                   draw_ready
);
  logic [WORD_W-1:0] mem [0:255];
  logic [ADDR_W-1:0] fetched [$];
  dlde_draw_s        drawn [$];
  int                mwait;
  int                dwait;

  // Word read after a short or long wait; idle bus toggles so stale data never matches
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack    <= 1'b0;
      mem_rdata  <= 32'h00000000;
      draw_ready <= 1'b0;
      mwait      <= 0;
      dwait      <= 0;
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
        fetched.push_back(mem_addr);
        mem_ack <= 1'b0;
        mwait   <= 0;
      end else if (mem_req) begin
        if (mwait >= (slow ? 3 : 0)) begin
          mem_ack   <= 1'b1;
          mem_rdata <= mem[mem_addr[7:0]];
        end else begin
          mwait <= mwait + 1;
        end
      end
      // Pipeline stalls a few cycles when slow
      if (draw_ready) begin
        drawn.push_back(draw);
        draw_ready <= 1'b0;
        dwait      <= 0;
      end else if (draw_valid) begin
        if (dwait >= (slow ? 4 : 0)) draw_ready <= 1'b1;
        else dwait <= dwait + 1;
      end
    end
  end
endmodule : dlde_far_model

// *** verification/testbench.sv ***
// Self-checking bench for the display list drawing engine
`timescale 1ns/10ps
module testbench;
  import dlde_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              start = 1'b0;
  logic [ADDR_W-1:0] start_addr = 24'h000000;
  logic              resume = 1'b0;
  logic              vsync_pin = 1'b0;
  logic              frame_pin = 1'b0;
  logic              dma_done = 1'b0;
  logic              slow = 1'b0;
  logic              mem_req, mem_ack, draw_valid, draw_ready, busy;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_rdata;
  dlde_draw_s        draw;
  dlde_irq_s         irq;
  dlde_irq_s         seen;
  logic              clr = 1'b0;
  int                n_errors = 0;
  int                total_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  dlde_engine uut (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
    .start_addr(start_addr), .resume(resume), .vsync_pin(vsync_pin),
    .frame_pin(frame_pin), .dma_done(dma_done), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .draw_valid(draw_valid), .draw(draw),
    .draw_ready(draw_ready), .irq(irq), .busy(busy));

  dlde_far_model far (.ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .draw_valid(draw_valid), .draw(draw), .draw_ready(draw_ready));

  // Sticky record of event pulses, since all but vblank last one cycle
  always @(posedge ref_clk) seen <= clr ? 7'h00 : (seen | irq);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_trace(input logic [23:0] exp [$]);
    chk("fetch count", exp.size(), far.fetched.size());
    foreach (exp[i]) chk("fetch addr", {8'h00, exp[i]}, {8'h00, far.fetched[i]});
  endtask : chk_trace

  // Command word then argument word
  task automatic put(input int a, input dlde_op_e op, input logic [23:0] lo,
                     input logic dep, input logic [31:0] arg);
    far.mem[a]   = {op, 1'b0, dep, 2'b00, lo};
    far.mem[a+1] = arg;
  endtask : put

  task automatic go(input logic [23:0] a);
    far.fetched.delete();
    far.drawn.delete();
    @(posedge ref_clk);
    clr <= 1'b1;
    start <= 1'b1;
    start_addr <= a;
    @(posedge ref_clk);
    clr <= 1'b0;
    start <= 1'b0;
  endtask : go

  // Bounded wait for the engine to go idle
  task automatic wait_idle();
    for (int k = 0; k < 500; k++) begin
      @(posedge ref_clk);
      #1;
      if (busy === 1'b0) break;
    end
    // One more edge so the sticky record holds the final event pulse
    @(posedge ref_clk);
    #1;
    chk("busy after list", 32'h0, {31'h0, busy});
  endtask : wait_idle

  task automatic t_reset();
    chk("busy", 32'h0, {31'h0, busy});
    chk("mem_addr", 32'h0, {8'h00, mem_addr});
    chk("outputs", 32'h0, {23'h0, mem_req, draw_valid, irq});
    $display("test reset done");
  endtask : t_reset

  // Targets of jump and call travel in the argument word
  task automatic t_jump();
    put(16, DLDE_OP_IDLE, 24'h0, 1'b0, 32'h0);
    put(18, DLDE_OP_JUMP, 24'h0, 1'b0, 32'h00000040);
    put(64, DLDE_OP_END, 24'h0, 1'b0, 32'h0);
    go(24'h000010);
    wait_idle();
    chk_trace('{24'h10, 24'h11, 24'h12, 24'h13, 24'h40, 24'h41});
    chk("cmd_end", 32'h1, {31'h0, seen.cmd_end});
    $display("test jump done");
  endtask : t_jump

  task automatic t_call();
    slow <= 1'b1;
    put(32, DLDE_OP_CALL, 24'h0, 1'b0, 32'h00000060);
    put(34, DLDE_OP_END, 24'h0, 1'b0, 32'h0);
    put(96, DLDE_OP_RET, 24'h0, 1'b0, 32'h0);
    go(24'h000020);
    wait_idle();
    chk_trace('{24'h20, 24'h21, 24'h60, 24'h61, 24'h22, 24'h23});
    slow <= 1'b0;
    $display("test call done");
  endtask : t_call

  task automatic t_nest();
    put(48, DLDE_OP_CALL, 24'h0, 1'b0, 32'h00000070);
    put(112, DLDE_OP_CALL, 24'h0, 1'b0, 32'h00000080);
    go(24'h000030);
    wait_idle();
    chk_trace('{24'h30, 24'h31, 24'h70, 24'h71});
    chk("err abort", 32'h3, {30'h0, seen.cmd_err, seen.cmd_abort});
    $display("test nest done");
  endtask : t_nest

  // Offset then each drawing kind; class table is source use, work dest, binary
  task automatic t_draw();
    logic [2:0] cls [4] = '{3'b100, 3'b000, 3'b111, 3'b010};
    dlde_draw_s d;
    slow <= 1'b1;
    put(144, DLDE_OP_OFFSET, 24'h0, 1'b0, {16'd5, 16'd7});
    for (int i = 0; i < 4; i++) begin
      put(146 + 2 * i, dlde_op_e'(i), 24'h001234, 1'b0, {16'(100 + i), 16'(200 + i)});
    end
    put(154, DLDE_OP_END, 24'h0, 1'b0, 32'h0);
    go(24'h000090);
    wait_idle();
    chk("draw count", 32'h4, far.drawn.size());
    for (int i = 0; i < 4; i++) begin
      d = far.drawn[i];
      chk("op", i, {28'h0, d.op});
      chk("class", {29'h0, cls[i]}, {29'h0, d.use_src, d.to_work, d.src_binary});
      chk("depth16", 32'h0, {31'h0, d.depth16});
      chk("screen", {16'(100 + i), 16'(200 + i)}, d.screen_xy);
      chk("render", {16'(105 + i), 16'(207 + i)}, d.render_xy);
      chk("src addr", 32'h1234, {8'h00, d.src_addr});
    end
    slow <= 1'b0;
    $display("test draw done");
  endtask : t_draw

  task automatic t_halt();
    logic any = 1'b0;
    put(160, DLDE_OP_INTR, 24'h0, 1'b0, 32'h0);
    put(162, DLDE_OP_END, 24'h0, 1'b0, 32'h0);
    go(24'h0000a0);
    for (int k = 0; k < 100 && far.fetched.size() < 2; k++) @(posedge ref_clk);
    dma_done <= 1'b1;
    @(posedge ref_clk);
    dma_done <= 1'b0;
    // Sample after the edge so the request seen is the settled one
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      any |= mem_req;
    end
    chk("fetch while halted", 32'h0, {31'h0, any});
    chk("busy halted", 32'h1, {31'h0, busy});
    chk("halt request", 32'h1, {31'h0, seen.cmd_end});
    chk("dma_end", 32'h1, {31'h0, seen.dma_end});
    @(posedge ref_clk);
    resume <= 1'b1;
    @(posedge ref_clk);
    resume <= 1'b0;
    wait_idle();
    chk_trace('{24'ha0, 24'ha1, 24'ha2, 24'ha3});
    $display("test halt done");
  endtask : t_halt

  task automatic t_vsync();
    put(176, DLDE_OP_VSYNC, 24'h0, 1'b0, 32'h0);
    put(178, DLDE_OP_END, 24'h0, 1'b0, 32'h0);
    go(24'h0000b0);
    repeat (30) @(posedge ref_clk);
    chk("fetches before sync", 32'h2, far.fetched.size());
    vsync_pin <= 1'b1;
    frame_pin <= 1'b1;
    wait_idle();
    chk_trace('{24'hb0, 24'hb1, 24'hb2, 24'hb3});
    chk("sync vblank frame", 32'h7, {29'h0, seen.sync_det, seen.vblank, seen.frame_det});
    vsync_pin <= 1'b0;
    frame_pin <= 1'b0;
    $display("test vsync done");
  endtask : t_vsync

  // Window lo.x from the command word, lo.y zero, hi from the argument;
  // the second point is inside once offset, so only a screen-space test clips it
  task automatic t_clip();
    logic       exp_clip [3] = '{1'b0, 1'b1, 1'b1};
    dlde_draw_s d;
    put(192, DLDE_OP_OFFSET, 24'h0, 1'b1, {16'h0005, 16'h0007});
    put(194, DLDE_OP_SCLIPW, 24'h00000a, 1'b0, {16'h00c8, 16'h0064});
    put(196, DLDE_OP_UCLIPW, 24'h0, 1'b0, {16'hffff, 16'hffff});
    put(198, DLDE_OP_LINE, 24'h0, 1'b0, {16'h0032, 16'h0032});
    put(200, DLDE_OP_LINE, 24'h0, 1'b0, {16'h0008, 16'h0032});
    put(202, DLDE_OP_UCLIPW, 24'h0, 1'b0, {16'h0028, 16'h0028});
    put(204, DLDE_OP_LINE, 24'h0, 1'b0, {16'h0032, 16'h0032});
    put(206, DLDE_OP_CPSET, 24'h0, 1'b0, 32'h0);
    put(208, DLDE_OP_END, 24'h0, 1'b0, 32'h0);
    far.mem[198][CLIP_BIT] = 1'b1;
    far.mem[200][CLIP_BIT] = 1'b1;
    far.mem[204][CLIP_BIT] = 1'b1;
    go(24'h0000c0);
    wait_idle();
    chk("fetch count", 32'h12, far.fetched.size());
    chk("draw count", 32'h3, far.drawn.size());
    for (int i = 0; i < 3; i++) begin
      d = far.drawn[i];
      chk("clip_en", 32'h1, {31'h0, d.clip_en});
      chk("clipped", {31'h0, exp_clip[i]}, {31'h0, d.clipped});
      chk("depth16", 32'h1, {31'h0, d.depth16});
    end
    $display("test clip done");
  endtask : t_clip

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_jump();
    t_call();
    t_nest();
    t_draw();
    t_halt();
    t_vsync();
    t_clip();
    summarize();
  end
endmodule : testbench
